// [bench/qpc_counter_tb.sv]
`timescale 1ns/1ps
`include "qpc_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module qpc_counter_tb;
    localparam logic [31:0] all_ones = 32'hffff_ffff;
    localparam logic [11:0] s0 = `QPC_OFF_SLOT0;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pins;
    logic        tick = 1'b0;
    logic        snap = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  strb = 4'hf;
    logic [3:0]  fault;
    logic [31:0] rv;
    logic        re;
    int          err_count = 0;
    int          checked = 0;
    int          cyc = 0;

    always #2.5 pclk = ~pclk;

    qpc_counter #(.NUM_GROUPS(4)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_pin(pins), .cycle_tick(tick), .input_sample_instant(snap),
        .encoder_fault_flag(fault)
    );

    qpc_enc_model enc (.pins(pins), .pclk(pclk));

    // =================================================================
    // bus and strobe helpers
    // request held until the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(re, 1'b0)
        `CHK(rv & m, e)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        `CHK(re, 1'b0)
    endtask

    // one-cycle module cycle tick or input sample instant
    task automatic strobe(input logic is_snap);
        @(posedge pclk);
        if (is_snap) snap <= 1'b1;
        else tick <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
        tick <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    // =================================================================
    // scenarios
    task automatic t_reset();
        rchk(`QPC_OFF_CTRL, all_ones, `QPC_CTRL_RESET);
        rchk(s0, all_ones, 32'h0000_0000);
        `CHK(fault, 4'h0)
    endtask

    task automatic t_bus();
        apb(1'b0, 12'h100, 32'h0000_0000);
        `CHK({re, rv}, 33'h1_0000_0000)
        apb(1'b1, s0, 32'h0000_0005);
        `CHK(re, 1'b1)
        rchk(s0, all_ones, 32'h0000_0000);
    endtask

    task automatic t_incr();
        wr(`QPC_OFF_CTRL, 32'h0008_0001);
        enc.quad(0, 1'b1, 8);
        rchk(s0, all_ones, 32'h0000_0008);
        rchk(s0 + 12'h004, all_ones, 32'h0000_0000);
        rchk(`QPC_OFF_STAT, 32'h0000_0f00, 32'h0000_0f00);
        enc.quad(0, 1'b0, 3);
        rchk(s0, all_ones, 32'h0000_0005);
        wr(`QPC_OFF_CTRL, 32'h0008_0005);
        enc.quad(0, 1'b1, 8);
        rchk(s0, all_ones, 32'hffff_fffd);
    endtask

    task automatic t_fault();
        enc.flip(8'h03);
        rchk(s0, all_ones, 32'hffff_fffd);
        `CHK(fault, 4'h1)
        rchk(`QPC_OFF_STAT, 32'h0000_000f, 32'h0000_0001);
        wr(`QPC_OFF_STAT, 32'h0000_0001);
        rchk(`QPC_OFF_STAT, 32'h0000_000f, 32'h0000_0000);
        `CHK(fault, 4'h0)
    endtask

    task automatic t_pulse();
        wr(`QPC_OFF_CTRL, 32'h0008_0025);
        repeat (3) begin
            enc.flip(8'h04);
            enc.flip(8'h04);
        end
        rchk(s0 + 12'h008, all_ones, 32'h0000_0003);
        @(posedge pclk);
        ce <= 1'b0;
        enc.flip(8'h04);
        enc.flip(8'h04);
        ce <= 1'b1;
        rchk(s0 + 12'h008, all_ones, 32'h0000_0003);
        enc.flip(8'h08);
        enc.flip(8'h08);
        rchk(s0 + 12'h008, all_ones, 32'h0000_0003);
        rchk(s0 + 12'h00c, all_ones, 32'h0000_0000);
        wr(`QPC_OFF_CTRL, 32'h0008_00a5);
        enc.flip(8'h04);
        rchk(s0 + 12'h008, all_ones, 32'h0000_0003);
        enc.flip(8'h04);
        rchk(s0 + 12'h008, all_ones, 32'h0000_0004);
    endtask

    task automatic t_usage();
        wr(`QPC_OFF_CTRL, 32'h0003_0025);
        rchk(`QPC_OFF_STAT, 32'h0000_0f00, 32'h0000_0100);
        rchk(s0 + 12'h008, all_ones, 32'h0000_0000);
        rchk(s0, all_ones, 32'hffff_fffd);
        strb <= 4'h4;
        wr(`QPC_OFF_CTRL, 32'h0004_00ff);
        strb <= 4'hf;
        rchk(`QPC_OFF_CTRL, all_ones, 32'h0004_0025);
        rchk(`QPC_OFF_STAT, 32'h0000_0f00, 32'h0000_0000);
        rchk(s0, all_ones, 32'h0000_0000);
    endtask

    task automatic t_iso();
        wr(`QPC_OFF_CTRL, 32'h0018_0001);
        strobe(1'b0);
        strobe(1'b1);
        rchk(s0, all_ones, 32'hffff_fffd);
        enc.quad(0, 1'b1, 2);
        rchk(s0, all_ones, 32'hffff_fffd);
        strobe(1'b1);
        rchk(s0, all_ones, 32'hffff_ffff);
        wr(`QPC_OFF_CTRL, 32'h0018_0000);
        enc.quad(0, 1'b1, 2);
        strobe(1'b1);
        rchk(s0, all_ones, 32'h0000_0001);
        wr(`QPC_OFF_CTRL, 32'h0000_0000);
        strobe(1'b0);
    endtask

    // =================================================================
    // verdict, main sequence and hang guard
    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_bus();
        t_incr();
        t_fault();
        t_pulse();
        t_usage();
        t_iso();
        test_done();
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
endmodule // qpc_counter_tb

// [bench/qpc_enc_model.sv]
`timescale 1ns/1ps

// =====================================================================
// encoder at the far side: two phases per group, pulses on the first pin
module qpc_enc_model (
    output logic      [7:0] pins,
    input  wire logic       pclk
);
    initial pins = 8'h00;

    // move the given pins together, then hold them past the synchroniser
    task automatic flip(input logic [7:0] m);
        @(posedge pclk);
        pins <= pins ^ m;
        repeat (4) @(posedge pclk);
    endtask

    // quarter-period steps: exactly one phase moves per step
    task automatic quad(input int g, input logic up, input int n);
        logic a;
        logic b;
        for (int i = 0; i < n; i++) begin
            a = pins[2*g];
            b = pins[2*g+1];
            if ((a == b) == up) begin
                flip(8'h01 << (2*g));
            end else begin
                flip(8'h02 << (2*g));
            end
        end
    endtask
endmodule // qpc_enc_model

// [rtl/qpc_counter.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "qpc_regs.svh"

// Summary of operation
// - each counter is signed 32 bit, range -2147483648 to 2147483647.
// - counting never stops; passing a limit loads the opposite limit.
// - software has no way to preset, load or change a counter.
// - incremental mode pairs two inputs of a group as phase A and B.
// - every rising and falling edge of both phases counts, four per period, except where both phases change at once.
// - direction comes from one phase's edge and the other phase's level.
// - a configuration bit inverts the decoded direction.
// - pulse mode counts rising or falling edges, as configured.
// - in pulse mode only the first input of a group counts.
// - incremental count appears in the first grouped input's slot.
// - the second grouped input's slot always reads zero.
// - pulse count appears in the slot of the pulse input.
// - eight inputs give four counters, three give one, otherwise none.
// - while the staged control has the iso bit set, control takes effect only at the module cycle tick; clearing it applies at once.
// - isochronous feedback is sampled at the input sample instant.
// - a transition with no phase offset raises an encoder fault.
module qpc_counter #(
    parameter int NUM_GROUPS = 4
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [2*NUM_GROUPS-1:0]   in_pin,
    input  wire logic                      cycle_tick,
    input  wire logic                      input_sample_instant,
    output logic      [NUM_GROUPS-1:0]     encoder_fault_flag
);

    localparam int NUM_IN = 2 * NUM_GROUPS;

    // =================================================================
    // parameter check
    initial begin
        if (NUM_GROUPS < 1 || NUM_GROUPS > 4) begin
            $error("NUM_GROUPS must be 1 to 4");
        end
    end

    // =================================================================
    // declarations
    logic [NUM_IN-1:0]          sync1;
    logic [NUM_IN-1:0]          sync2;
    logic [31:0]                ctrl;
    logic [31:0]                active;
    logic [NUM_GROUPS-1:0]      grp_allowed;
    logic [NUM_GROUPS-1:0]      fault_sticky;
    logic [NUM_GROUPS-1:0]      snap_fault;
    logic signed [31:0]         snap_cnt [NUM_GROUPS];
    qpc_pkg::qpc_cnt_out_t      cnt [NUM_GROUPS];
    qpc_pkg::qpc_grp_cfg_t      gcfg [NUM_GROUPS];
    logic [3:0]                 usage;
    logic                       iso;
    logic                       rd_valid;
    logic                       slverr_q;
    logic                       wr_fire;
    logic                       load;
    logic                       is_ctrl;
    logic                       is_stat;
    logic                       is_slot;
    logic [3:0]                 slot_idx;
    logic [31:0]                next_rdata;
    logic                       next_err;
    logic [NUM_GROUPS-1:0]      stat_clear;
    logic [31:0]                stat_word;

    // =================================================================
    // input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else if (ce) begin
                    sync1[gi] <= in_pin[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // =================================================================
    // apb decode
    assign pready  = ce & rd_valid;
    assign pslverr = pready & slverr_q;
    assign wr_fire = psel & penable & pwrite & pready;
    assign load    = ce & psel & ~(penable & pready);

    assign is_ctrl  = (paddr == `QPC_OFF_CTRL);
    assign is_stat  = (paddr == `QPC_OFF_STAT);
    assign slot_idx = 4'((paddr - `QPC_OFF_SLOT0) >> 2);
    assign is_slot  = (paddr >= `QPC_OFF_SLOT0) && (paddr[1:0] == 2'b00)
                      && ((paddr - `QPC_OFF_SLOT0) < 12'(4 * NUM_IN));

    // =================================================================
    // answer flops, loaded in setup or while waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= psel & ~(penable & pready);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (load) begin
            prdata   <= pwrite ? 32'h0000_0000 : next_rdata;
            slverr_q <= next_err;
        end
    end

    // =================================================================
    // control register, staged by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `QPC_CTRL_RESET;
        end else if (wr_fire && is_ctrl) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    ctrl[8*b +: 8] <= pwdata[8*b +: 8];
                end
            end
        end
    end

    // =================================================================
    // active control, applied at the module cycle in iso mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= `QPC_CTRL_RESET;
        end else if (ce && (!ctrl[`QPC_CTRL_ISO_BIT] || cycle_tick)) begin
            active <= ctrl;
        end
    end

    assign iso   = active[`QPC_CTRL_ISO_BIT];
    assign usage = active[`QPC_CTRL_USAGE_LSB +: 4];

    // =================================================================
    // counters available for the input usage
    always_comb begin
        grp_allowed = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (usage == `QPC_USAGE_FULL) begin
                grp_allowed[g] = 1'b1;
            end else if (usage == `QPC_USAGE_ONE) begin
                grp_allowed[g] = (g == 0);
            end
        end
    end

    // =================================================================
    // per-group decoders
    generate
        for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_cnt
            assign gcfg[gi] = qpc_pkg::qpc_grp_cfg_t'(active[4*gi +: 4]);

            qpc_decoder u_dec (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .phase_a (sync2[2*gi]),
                .phase_b (sync2[2*gi+1]),
                .enable  (grp_allowed[gi]),
                .cfg     (gcfg[gi]),
                .result  (cnt[gi])
            );
        end
    endgenerate

    // =================================================================
    // sticky encoder fault, write one to clear, set wins
    always_comb begin
        stat_clear = '0;
        if (wr_fire && is_stat && pstrb[0]) begin
            stat_clear = pwdata[`QPC_STAT_FAULT_LSB +: NUM_GROUPS];
        end
    end

    generate
        for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_flt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fault_sticky[gi] <= 1'b0;
                end else if (ce) begin
                    if (cnt[gi].fault) begin
                        fault_sticky[gi] <= 1'b1;
                    end else if (stat_clear[gi]) begin
                        fault_sticky[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // =================================================================
    // feedback snapshot at the input sample instant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                snap_cnt[g] <= `QPC_CNT_RESET;
            end
            snap_fault <= '0;
        end else if (ce && input_sample_instant) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                snap_cnt[g] <= cnt[g].value;
            end
            snap_fault <= fault_sticky;
        end
    end

    assign encoder_fault_flag = iso ? snap_fault : fault_sticky;

    // =================================================================
    // read mux; value slots are read only
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`QPC_STAT_FAULT_LSB +: NUM_GROUPS] = encoder_fault_flag;
        stat_word[`QPC_STAT_ENA_LSB +: NUM_GROUPS]   = grp_allowed;
        stat_word[`QPC_STAT_PIN_LSB +: NUM_IN]       = sync2;
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (is_ctrl) begin
            next_rdata = ctrl;
        end else if (is_stat) begin
            next_rdata = stat_word;
        end else if (is_slot) begin
            next_err = pwrite;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (slot_idx == 4'(2*g) && grp_allowed[g]
                    && gcfg[g].mode != qpc_pkg::QPC_MODE_OFF
                    && gcfg[g].mode != qpc_pkg::QPC_MODE_RSVD) begin
                    next_rdata = iso ? snap_cnt[g] : cnt[g].value;
                end
            end
        end else begin
            next_err = 1'b1;
        end
    end

    // =================================================================
    // checks
    property p_slot_zero;
        @(posedge pclk) disable iff (!presetn)
        (pready && psel && penable && !pwrite && is_slot && slot_idx[0]) |-> prdata == 32'h0;
    endproperty
    a_slot_zero: assert property (p_slot_zero) else $error("second slot not zero");

    property p_no_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && is_slot) |-> pslverr
            ##1 ($stable(cnt[0].value) || $past(g_cnt[0].u_dec.step));
    endproperty
    a_no_write: assert property (p_no_write) else $error("slot write accepted");

    property p_iso_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl[`QPC_CTRL_ISO_BIT] && !cycle_tick) |=> active == $past(active);
    endproperty
    a_iso_hold: assert property (p_iso_hold) else $error("control applied off cycle");

    property p_snap;
        @(posedge pclk) disable iff (!presetn)
        (ce && input_sample_instant) |=> snap_cnt[0] == $past(cnt[0].value);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot missed count");

    property p_usage;
        @(posedge pclk) disable iff (!presetn)
        (usage != `QPC_USAGE_FULL && usage != `QPC_USAGE_ONE) |-> grp_allowed == '0;
    endproperty
    a_usage: assert property (p_usage) else $error("counter on bad usage");

    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        (ce && psel && !penable) ##1 (ce && penable) |-> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("access phase not answered");

endmodule // qpc_counter

// [rtl/qpc_decoder.sv]
`timescale 1ns/1ps
`include "qpc_regs.svh"

module qpc_decoder (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    input  wire logic                 phase_a,
    input  wire logic                 phase_b,
    input  wire logic                 enable,
    input  qpc_pkg::qpc_grp_cfg_t     cfg,
    output qpc_pkg::qpc_cnt_out_t     result
);

    logic               a_q;
    logic               b_q;
    logic signed [31:0] count;
    logic               fault_q;
    logic               a_chg;
    logic               b_chg;
    logic               incr;
    logic               step;
    logic               up;

    assign a_chg = phase_a ^ a_q;
    assign b_chg = phase_b ^ b_q;
    assign incr  = enable && (cfg.mode == qpc_pkg::QPC_MODE_INCR);

    // =================================================================
    // edge evaluation
    always_comb begin
        step = 1'b0;
        up   = 1'b1;
        if (incr) begin
            step = a_chg ^ b_chg;
            up   = (a_chg ? (phase_a ^ phase_b) : ~(phase_a ^ phase_b)) ^ cfg.invert;
        end else if (enable && cfg.mode == qpc_pkg::QPC_MODE_PULSE) begin
            step = cfg.falling ? (a_q & ~phase_a) : (~a_q & phase_a);
            up   = ~cfg.invert;
        end
    end

    // =================================================================
    // state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else if (ce) begin
            a_q <= phase_a;
            b_q <= phase_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `QPC_CNT_RESET;
        end else if (ce && step) begin
            count <= up ? count + 32'sd1 : count - 32'sd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else if (ce) begin
            fault_q <= incr & a_chg & b_chg;
        end
    end

    assign result.value = count;
    assign result.fault = fault_q;

    // =================================================================
    // checks
    property p_step;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (count == $past(count)) || (count == $past(count) + 32'sd1)
                 || (count == $past(count) - 32'sd1);
    endproperty
    a_step: assert property (p_step) else $error("count moved by more than one");

    property p_both;
        @(posedge pclk) disable iff (!presetn)
        (ce && incr && a_chg && b_chg) |=> (count == $past(count)) && fault_q;
    endproperty
    a_both: assert property (p_both) else $error("double change not ignored");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (ce && step && up && count == `QPC_CNT_MAX) |=> count == `QPC_CNT_MIN;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at upper limit");

    property p_quad;
        @(posedge pclk) disable iff (!presetn)
        (ce && incr && !cfg.invert && !a_q && phase_a && !b_chg && !phase_b)
            |=> count == $past(count) + 32'sd1;
    endproperty
    a_quad: assert property (p_quad) else $error("rising A with B low not up");

endmodule // qpc_decoder

// [rtl/qpc_pkg.sv]
package qpc_pkg;

    // =================================================================
    // counting modes of a channel group
    typedef enum logic [1:0] {
        QPC_MODE_OFF,
        QPC_MODE_INCR,
        QPC_MODE_PULSE,
        QPC_MODE_RSVD
    } qpc_mode_t;

    // per-group configuration nibble
    typedef struct packed {
        logic      falling;
        logic      invert;
        qpc_mode_t mode;
    } qpc_grp_cfg_t;

    // what a counter hands back
    typedef struct packed {
        logic signed [31:0] value;
        logic               fault;
    } qpc_cnt_out_t;

endpackage

// [rtl/qpc_regs.svh]
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH

// =====================================================================
// register offsets (byte addresses)
`define QPC_OFF_CTRL        12'h000
`define QPC_OFF_STAT        12'h004
`define QPC_OFF_SLOT0       12'h010

// =====================================================================
// field positions
`define QPC_CTRL_GRP_W      4
`define QPC_CTRL_USAGE_LSB  16
`define QPC_CTRL_ISO_BIT    20
`define QPC_STAT_FAULT_LSB  0
`define QPC_STAT_ENA_LSB    8
`define QPC_STAT_PIN_LSB    16

// =====================================================================
// reset values and codes
`define QPC_CTRL_RESET      32'h0000_0000
`define QPC_USAGE_FULL      4'h8
`define QPC_USAGE_ONE       4'h3
`define QPC_CNT_RESET       32'sh0000_0000
`define QPC_CNT_MAX         32'sh7fff_ffff
`define QPC_CNT_MIN         32'sh8000_0000

`endif
